// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	typedef struct {logic [7:0] own, ctl; logic slp, arb; logic [7:0] adr, st1, st2;} tws_row_t;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, arb_lost_i, a;
	logic [4:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [7:0] q;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, wake_o, start_queued_o, m_scl, m_sda;
	wire scl_w = (scl_oe_o ? scl_o : 1'b1) & !m_scl;
	wire sda_w = (sda_oe_o ? sda_o : 1'b1) & !m_sda;
	int err_total, checks_done, cycles;
	logic [7:0] rst_exp [6] = '{8'h00, 8'h00, 8'hF8, 8'hFF, 8'h00, 8'h00};
	tws_row_t rows [11] = '{
		'{8'hA4, 8'h44, 0, 0, 8'hA4, 8'h60, 8'h80}, '{8'hA4, 8'h44, 0, 0, 8'hA6, 8'hF8, 8'h80},
		'{8'hA4, 8'h44, 0, 0, 8'hA5, 8'hF8, 8'h80}, '{8'hA4, 8'h44, 0, 0, 8'h00, 8'hF8, 8'h80},
		'{8'hA4, 8'h04, 0, 0, 8'hA4, 8'hF8, 8'h80}, '{8'hA5, 8'h44, 0, 0, 8'h00, 8'h70, 8'h90},
		'{8'hA4, 8'h44, 0, 0, 8'hA4, 8'h60, 8'h88}, '{8'hA5, 8'h44, 0, 0, 8'h00, 8'h70, 8'h98},
		'{8'hA4, 8'h44, 0, 1, 8'hA4, 8'h68, 8'h80}, '{8'hA5, 8'h44, 0, 1, 8'h00, 8'h78, 8'h90},
		'{8'hA4, 8'h44, 1, 0, 8'hA4, 8'h60, 8'h80}};
	tws_slave_rx u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_w), .scl_o(scl_o),
		.scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.arb_lost_i(arb_lost_i), .wake_o(wake_o), .start_queued_o(start_queued_o));
	tws_mst_model u_mst (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl), .sda_low_o(m_sda));
	task summarize();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Classic single cycle, held until ack is sampled high at an edge; data taken there
	task wb(input logic w, input logic [4:0] ad, input logic [7:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_sel_i <= 4'hF;
		wb_adr_i <= ad;
		wb_dat_i <= {24'h0, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// Polls the control register for the flag
	task wait_flag();
		for (int k = 0; k < 40; k++) begin
			wb(0, 5'h04, 8'h00);
			if (q[7] === 1'b1) break;
		end
		check(q & 8'h80, 8'h80);
	endtask
	// Free-running system clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// Hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			summarize();
		end
	end
	// Table of transfers, then reset values
	initial begin
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, arb_lost_i} = 4'h0;
		wb_adr_i = 5'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			wb(1, 5'h00, rows[i].own);
			wb(1, 5'h10, {7'h0, rows[i].slp});
			wb(1, 5'h08, 8'h03);
			wb(1, 5'h04, rows[i].ctl);
			arb_lost_i <= rows[i].arb;
			u_mst.start();
			u_mst.xfer(rows[i].adr, a);
			check(a, rows[i].st1 != 8'hF8);
			if (a) begin
				wait_flag();
				check(wake_o, rows[i].slp);
				check({4'h0, scl_o, sda_o, sda_oe_o, scl_oe_o}, 8'h01);
				wb(0, 5'h08, 8'h00);
				check(q & 8'hF8, rows[i].st1);
				wb(1, 5'h04, rows[i].st2[3] ? 8'h84 : 8'hC4);
				u_mst.xfer(rows[i].adr ^ 8'h5A, a);
				check(a, !rows[i].st2[3]);
				wait_flag();
				wb(0, 5'h08, 8'h00);
				check(q & 8'hF8, rows[i].st2);
				wb(0, 5'h0C, 8'h00);
				if (!rows[i].slp) check(q, rows[i].adr ^ 8'h5A);
				wb(1, 5'h04, {2'b11, rows[i].st2[3], 5'h04});
			end
			u_mst.stop();
			if (a) begin
				wait_flag();
				wb(0, 5'h08, 8'h00);
				check(q & 8'hF8, 8'hA0);
				wb(1, 5'h04, 8'hC4);
			end
			wb(0, 5'h08, 8'h00);
			check(q & 8'hF8, 8'hF8);
			check(q & 8'h07, 8'h03);
			check({7'h00, start_queued_o}, {7'h00, rows[i].st2[3]});
			$display("row %0d done", i);
		end
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1, 5'h14, 8'h5A);
		for (int k = 0; k < 6; k++) begin
			wb(0, 5'(k * 4), 8'h00);
			check(q, rst_exp[k]);
		end
		$display("reset test done");
		summarize();
	end
endmodule // tb_top

// ---- tws_cond.v ----
`timescale 1ns/1ps
// Finds clock edges and start and stop conditions on synced lines
module tws_cond (
	input wire clk_i,
	input wire rst_i,
	input wire scl_i,
	input wire sda_i,
	output wire scl_rise_o,
	output wire scl_fall_o,
	output wire start_o,
	output wire stop_o
);
	reg scl_q;
	reg sda_q;

	// Previous line levels
	always @(posedge clk_i) begin
		if (rst_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	// Data edges while clock high are conditions
	assign scl_rise_o = scl_i & ~scl_q;
	assign scl_fall_o = ~scl_i & scl_q;
	assign start_o = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_o = scl_i & scl_q & ~sda_q & sda_i;
endmodule // tws_cond

// ---- tws_consts.vh ----
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH

// Register word indexes, byte address is four times the index
`define TWS_IDX_OWN 3'h0
`define TWS_IDX_CTRL 3'h1
`define TWS_IDX_STAT 3'h2
`define TWS_IDX_DATA 3'h3
`define TWS_IDX_PWR 3'h4

// Control register bit positions
`define TWS_CB_INT 7
`define TWS_CB_ACK 6
`define TWS_CB_STA 5
`define TWS_CB_STO 4
`define TWS_CB_WCOL 3
`define TWS_CB_EN 2
`define TWS_CB_IE 0

// Power register bit position
`define TWS_PB_SLEEP 0

// Status codes, prescaler bits zero
`define TWS_ST_OWN_W 8'h60
`define TWS_ST_ARB_OWN 8'h68
`define TWS_ST_GC 8'h70
`define TWS_ST_ARB_GC 8'h78
`define TWS_ST_DATA_ACK 8'h80
`define TWS_ST_DATA_NACK 8'h88
`define TWS_ST_GC_ACK 8'h90
`define TWS_ST_GC_NACK 8'h98
`define TWS_ST_STOP 8'hA0
`define TWS_ST_IDLE 8'hF8

// Reset values
`define TWS_RST_OWN 8'h00
`define TWS_RST_CTRL 8'h00
`define TWS_RST_DATA 8'hFF
`define TWS_RST_PRESC 2'h0

// Bits per byte on the wire
`define TWS_BITS_BYTE 4'h8

`endif

// ---- tws_mst_model.sv ----
`timescale 1ns/1ps
// Master transmitter on the far side; lines are pulled up when released
module tws_mst_model (
	input wire scl_i,
	input wire sda_i,
	output logic scl_low_o,
	output logic sda_low_o
);
	// Both lines released at start
	initial begin
		scl_low_o <= 1'b0;
		sda_low_o <= 1'b0;
	end
	// One bit, 80 ns, waits out clock stretching; NBA keeps pin edges off the clock race
	task bit_io(input logic b, output logic r);
		sda_low_o <= !b;
		#20 scl_low_o <= 1'b0;
		wait (scl_i === 1'b1);
		#20 r = sda_i;
		#20 scl_low_o <= 1'b1;
		#20;
	endtask
	// Start or repeated start
	task start();
		sda_low_o <= 1'b0;
		#20 scl_low_o <= 1'b0;
		wait (scl_i === 1'b1);
		#40 sda_low_o <= 1'b1;
		#40 scl_low_o <= 1'b1;
		#20;
	endtask
	// Stop, clock then stands high
	task stop();
		sda_low_o <= 1'b1;
		#20 scl_low_o <= 1'b0;
		wait (scl_i === 1'b1);
		#40 sda_low_o <= 1'b0;
		#40;
	endtask
	// Byte MSB first, ninth clock reads the answer
	task xfer(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
endmodule // tws_mst_model

// ---- tws_slave_rx.v ----
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "tws_consts.vh"

module tws_slave_rx (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [4:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire scl_i,
	output reg scl_o,
	output reg scl_oe_o,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_o,
	input wire arb_lost_i,
	output reg wake_o,
	output reg start_queued_o
);
	// FSM states
	localparam S_IDLE = 3'h0;
	localparam S_ADDR = 3'h1;
	localparam S_AACK = 3'h2;
	localparam S_WAIT = 3'h3;
	localparam S_DATA = 3'h4;
	localparam S_DACK = 3'h5;
	localparam S_SKIP = 3'h6;

	// Registers seen by software
	reg [7:0] own_slave_address;
	reg interrupt_flag;
	reg ack_enable;
	reg start_request;
	reg stop_request;
	reg write_collision;
	reg interface_enable;
	reg interrupt_enable;
	reg [7:0] status_code;
	reg [1:0] prescaler;
	reg [7:0] serial_data_reg;
	reg sleep_deep;

	// Receiver state
	reg [2:0] state;
	reg [3:0] bit_cnt;
	reg [7:0] shift;
	reg gc_mode;
	reg ack_bit;
	reg after_nack;
	reg hw_set_flag;
	reg [7:0] hw_status;

	wire scl_s;
	wire sda_s;
	wire scl_rise;
	wire scl_fall;
	wire start_det;
	wire stop_det;
	wire bus_req;
	wire wr_stb;
	wire rd_stb;
	wire [2:0] idx;
	wire mapped;
	wire [7:0] ctrl_rd;
	wire own_hit;
	wire gc_hit;
	wire byte_done;
	wire addressed;

	// Pin synchronisers
	tws_sync #(
		.W(2)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({scl_i, sda_i}),
		.q_o({scl_s, sda_s})
	);

	// Bus condition finder
	tws_cond u_cond (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.scl_i(scl_s),
		.sda_i(sda_s),
		.scl_rise_o(scl_rise),
		.scl_fall_o(scl_fall),
		.start_o(start_det),
		.stop_o(stop_det)
	);

	// Status code after an acknowledged address
	function [7:0] addr_code;
		input gc;
		input arb;
		begin
			case ({gc, arb})
				2'b00: addr_code = `TWS_ST_OWN_W;
				2'b01: addr_code = `TWS_ST_ARB_OWN;
				2'b10: addr_code = `TWS_ST_GC;
				default: addr_code = `TWS_ST_ARB_GC;
			endcase
		end
	endfunction

	// Status code after a data byte
	function [7:0] data_code;
		input gc;
		input ack;
		begin
			case ({gc, ack})
				2'b01: data_code = `TWS_ST_DATA_ACK;
				2'b00: data_code = `TWS_ST_DATA_NACK;
				2'b11: data_code = `TWS_ST_GC_ACK;
				default: data_code = `TWS_ST_GC_NACK;
			endcase
		end
	endfunction

	// Bus decode
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign idx = wb_adr_i[4:2];
	assign mapped = (idx <= `TWS_IDX_PWR);
	assign wr_stb = bus_req & wb_we_i & wb_sel_i[0];
	assign rd_stb = bus_req & ~wb_we_i;
	assign ctrl_rd = {interrupt_flag, ack_enable, start_request, stop_request,
		write_collision, interface_enable, 1'b0, interrupt_enable};

	// Address recognition, general call gated by own address bit 0
	assign own_hit = (shift[7:1] == own_slave_address[7:1]);
	assign gc_hit = (shift[7:1] == 7'h00) & own_slave_address[0];
	assign byte_done = scl_fall & (bit_cnt == `TWS_BITS_BYTE);
	assign addressed = (state == S_DATA) | (state == S_DACK) | (state == S_WAIT);

	// Bus slave: one-cycle ack, registered read data
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			if (rd_stb) begin
				case (idx)
					`TWS_IDX_OWN: wb_dat_o <= {24'h000000, own_slave_address};
					`TWS_IDX_CTRL: wb_dat_o <= {24'h000000, ctrl_rd};
					`TWS_IDX_STAT: wb_dat_o <= {24'h000000, status_code[7:3], 1'b0, prescaler};
					`TWS_IDX_DATA: wb_dat_o <= {24'h000000, serial_data_reg};
					`TWS_IDX_PWR: wb_dat_o <= {31'h00000000, sleep_deep};
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	// Software registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			own_slave_address <= `TWS_RST_OWN;
			ack_enable <= |(`TWS_RST_CTRL & (8'h01 << `TWS_CB_ACK));
			start_request <= 1'b0;
			stop_request <= 1'b0;
			interface_enable <= 1'b0;
			interrupt_enable <= 1'b0;
			prescaler <= `TWS_RST_PRESC;
			sleep_deep <= 1'b0;
		end else if (wr_stb && mapped) begin
			case (idx)
				`TWS_IDX_OWN: own_slave_address <= wb_dat_i[7:0];
				`TWS_IDX_CTRL: begin
					ack_enable <= wb_dat_i[`TWS_CB_ACK];
					start_request <= wb_dat_i[`TWS_CB_STA];
					stop_request <= wb_dat_i[`TWS_CB_STO];
					interface_enable <= wb_dat_i[`TWS_CB_EN];
					interrupt_enable <= wb_dat_i[`TWS_CB_IE];
				end
				`TWS_IDX_STAT: prescaler <= wb_dat_i[1:0];
				`TWS_IDX_PWR: sleep_deep <= wb_dat_i[`TWS_PB_SLEEP];
				default: ;
			endcase
		end
	end

	// Interrupt flag: hardware set beats software clear
	always @(posedge clk_i) begin
		if (rst_i) begin
			interrupt_flag <= 1'b0;
			status_code <= `TWS_ST_IDLE;
		end else if (hw_set_flag) begin
			interrupt_flag <= 1'b1;
			status_code <= hw_status;
		end else if (wr_stb && idx == `TWS_IDX_CTRL && wb_dat_i[`TWS_CB_INT]) begin
			interrupt_flag <= 1'b0;
			if (after_nack || !addressed) begin
				status_code <= `TWS_ST_IDLE;
			end
		end
	end

	// Write collision: data write while flag low
	always @(posedge clk_i) begin
		if (rst_i) begin
			write_collision <= 1'b0;
		end else if (wr_stb && idx == `TWS_IDX_DATA) begin
			write_collision <= ~interrupt_flag;
		end
	end

	// Receiver engine
	always @(posedge clk_i) begin
		if (rst_i) begin
			state <= S_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			gc_mode <= 1'b0;
			ack_bit <= 1'b0;
			after_nack <= 1'b0;
			hw_set_flag <= 1'b0;
			hw_status <= `TWS_ST_IDLE;
			serial_data_reg <= `TWS_RST_DATA;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			wake_o <= 1'b0;
			start_queued_o <= 1'b0;
		end else begin
			hw_set_flag <= 1'b0;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			// Wake indication lasts until sleep is left
			if (!sleep_deep) begin
				wake_o <= 1'b0;
			end
			// Queued start dropped when request withdrawn
			if (!start_request || !interface_enable) begin
				start_queued_o <= 1'b0;
			end
			if (!interface_enable) begin
				state <= S_IDLE;
				scl_oe_o <= 1'b0;
				sda_oe_o <= 1'b0;
			end else if ((start_det || stop_det) && addressed) begin
				// Stop or restart while addressed
				hw_status <= `TWS_ST_STOP;
				hw_set_flag <= 1'b1;
				after_nack <= 1'b1;
				scl_oe_o <= 1'b0;
				sda_oe_o <= 1'b0;
				start_queued_o <= start_request;
				bit_cnt <= 4'h0;
				state <= start_det ? S_ADDR : S_IDLE;
			end else if (start_det) begin
				// Bus is monitored even with ack disabled
				sda_oe_o <= 1'b0;
				bit_cnt <= 4'h0;
				state <= S_ADDR;
			end else if (stop_det) begin
				sda_oe_o <= 1'b0;
				state <= S_IDLE;
			end else begin
				case (state)
					S_IDLE: begin
						bit_cnt <= 4'h0;
					end
					S_ADDR: begin
						if (scl_rise && bit_cnt != `TWS_BITS_BYTE) begin
							shift <= {shift[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (byte_done) begin
							if (ack_enable && !shift[0] && (own_hit || gc_hit)) begin
								// Write direction: acknowledge and receive
								gc_mode <= ~own_hit & gc_hit;
								sda_oe_o <= 1'b1;
								state <= S_AACK;
								if (sleep_deep) begin
									wake_o <= 1'b1;
								end
							end else begin
								// Not ours, read, or ack disabled
								state <= S_SKIP;
							end
						end
					end
					S_AACK: begin
						if (scl_fall) begin
							sda_oe_o <= 1'b0;
							scl_oe_o <= 1'b1;
							hw_status <= addr_code(gc_mode, arb_lost_i);
							hw_set_flag <= 1'b1;
							after_nack <= 1'b0;
							state <= S_WAIT;
						end
					end
					S_WAIT: begin
						// Stretch clock until software clears flag
						if (!interrupt_flag && !hw_set_flag) begin
							scl_oe_o <= 1'b0;
							bit_cnt <= 4'h0;
							if (after_nack) begin
								start_queued_o <= start_request;
								state <= S_IDLE;
							end else begin
								ack_bit <= ack_enable;
								state <= S_DATA;
							end
						end else begin
							scl_oe_o <= 1'b1;
						end
					end
					S_DATA: begin
						if (scl_rise && bit_cnt != `TWS_BITS_BYTE) begin
							shift <= {shift[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (byte_done) begin
							sda_oe_o <= ack_bit;
							state <= S_DACK;
						end
					end
					S_DACK: begin
						if (scl_fall) begin
							sda_oe_o <= 1'b0;
							scl_oe_o <= 1'b1;
							if (!wake_o) begin
								serial_data_reg <= shift;
							end
							hw_status <= data_code(gc_mode, ack_bit);
							hw_set_flag <= 1'b1;
							after_nack <= ~ack_bit;
							state <= S_WAIT;
						end
					end
					S_SKIP: begin
						bit_cnt <= 4'h0;
					end
					default: begin
						state <= S_IDLE;
					end
				endcase
			end
		end
	end
endmodule // tws_slave_rx

// ---- tws_slave_rx_checker.sv ----
`timescale 1ns/1ps
module tws_slave_rx_checker (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [4:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire scl_i,
	input wire scl_oe_o,
	input wire sda_oe_o,
	input wire wake_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [3:0] clr_age;
	// Software write of one to the flag, at its taking edge
	wire clr_req = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i[4:2] == 3'h1
		&& wb_sel_i[0] && wb_dat_i[7];
	// Cycles since the last flag clear, saturating
	always @(posedge clk_i) begin
		if (rst_i || clr_req) clr_age <= 4'h0;
		else if (clr_age != 4'hF) clr_age <= clr_age + 4'h1;
	end
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked next cycle");
	rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	scl_release_a: assert property (clr_req && scl_oe_o |-> ##[1:4] !scl_oe_o)
		else $error("clock not released after clear");
	scl_hold_a: assert property ($fell(scl_oe_o) |-> clr_age <= 4'h4)
		else $error("clock released without clear");
	wake_hold_a: assert property ($rose(wake_o) |-> ##[0:40] scl_oe_o)
		else $error("wake without clock hold");
	ack_len_a: assert property ($rose(sda_oe_o) |-> sda_oe_o [*2] ##[1:30] !sda_oe_o)
		else $error("ack bit length wrong");
	sda_low_scl_a: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data changed while clock high");
	cover property ($rose(scl_oe_o));
	cover property ($rose(wake_o));
	cover property (clr_req && scl_oe_o);
endmodule // tws_slave_rx_checker

bind tws_slave_rx tws_slave_rx_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.scl_i(scl_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o), .wake_o(wake_o));

// ---- tws_sync.v ----
`timescale 1ns/1ps
// Two-stage synchroniser for pins; idle level is high
module tws_sync #(
	parameter W = 2
) (
	input wire clk_i,
	input wire rst_i,
	input wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	reg [W-1:0] meta;
	reg [W-1:0] safe;

	// First stage feeds only the second
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta <= {W{1'b1}};
			safe <= {W{1'b1}};
		end else begin
			meta <= d_i;
			safe <= meta;
		end
	end

	assign q_o = safe;
endmodule // tws_sync
